// ===== bench/flash_model.sv
`timescale 1ns/1ns
module flash_model (
  // Serial link.
  input wire i_sck,
  input wire i_mosi,
  input wire i_sel_n,
  output reg o_miso,
  // Link settings.
  input wire [1:0] i_mode,
  input wire i_lsb
);
  reg [7:0] rx_q [0:15];
  reg [7:0] sh;
  reg [7:0] tx;
  integer nb = 0;
  integer nbit = 0;
  initial o_miso = 1'b0;
  // Byte k of a transaction answers 3C plus 11 times k.
  always @(negedge i_sel_n) begin
    nb = 0;
    nbit = 0;
    tx = 8'h3C;
    if (!i_mode[0]) o_miso = tx[i_lsb ? 0 : 7];
  end
  // A released line shows the inverse of its last value.
  always @(posedge i_sel_n) o_miso = ~o_miso;
  always @(i_sck) begin
    if (i_sel_n === 1'b0) begin
      if ((i_sck != i_mode[1]) != i_mode[0]) begin
        sh[i_lsb ? nbit : 7 - nbit] = i_mosi;
        nbit = nbit + 1;
        if (nbit == 8) begin
          rx_q[nb] = sh;
          nb = nb + 1;
          nbit = 0;
          tx = 8'h3C + 8'h11 * nb[7:0];
        end
      end else begin
        o_miso = tx[i_lsb ? nbit : 7 - nbit];
      end
    end
  end
endmodule

// ===== bench/spi_flash_dma_chk.sv
`timescale 1ns/1ns
module spi_flash_dma_chk (
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_rst,
  // Inputs watched.
  input wire [1:0] i_mode,
  input wire i_transaction_go,
  input wire i_complete_clear,
  input wire i_hready,
  input wire i_general_pin_sel,
  input wire i_general_pin_out,
  input wire i_general_pin_oe,
  // Outputs watched.
  input wire o_busy,
  input wire o_transaction_complete,
  input wire o_sck,
  input wire o_flash_select_n,
  input wire [1:0] o_htrans,
  input wire [2:0] o_hsize,
  input wire [31:0] o_haddr,
  input wire o_hwrite,
  input wire o_general_pin_out,
  input wire o_general_pin_oe
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  chk_go_starts: assert property (i_transaction_go && !o_busy |=> o_busy && !o_flash_select_n)
    else $error("start not taken");
  chk_done_release: assert property ($rose(o_transaction_complete) |-> $past(o_busy) && !o_busy && o_flash_select_n)
    else $error("select not released at done");
  chk_select_busy: assert property (o_busy != o_flash_select_n)
    else $error("select and busy disagree");
  chk_sck_idle: assert property ($rose(o_flash_select_n) |-> o_sck == i_mode[1])
    else $error("clock not at idle level");
  chk_done_sticky: assert property (o_transaction_complete && !i_complete_clear |=> o_transaction_complete)
    else $error("done flag lost");
  chk_one_xfer: assert property (o_htrans == 2'h2 && i_hready |=> o_htrans == 2'h0)
    else $error("bus transfers pipelined");
  chk_addr_hold: assert property (o_htrans == 2'h2 && !i_hready |=> o_htrans == 2'h2 && $stable(o_haddr) && $stable(o_hwrite))
    else $error("address phase dropped");
  chk_word_size: assert property (o_htrans == 2'h2 |-> o_hsize == 3'h2)
    else $error("transfer not word sized");
  chk_bus_quiet: assert property (!o_busy |-> o_htrans == 2'h0)
    else $error("bus active while idle");
  chk_pin_bypass: assert property (i_general_pin_sel |-> o_general_pin_out == o_flash_select_n && o_general_pin_oe)
    else $error("pin not bypassed");
  chk_pin_pass: assert property (!i_general_pin_sel |-> o_general_pin_out == i_general_pin_out && o_general_pin_oe == i_general_pin_oe)
    else $error("pin not passed through");
  cover property ($rose(o_transaction_complete));
  cover property (o_htrans == 2'h2 && o_hwrite && i_hready);
  cover property (o_htrans == 2'h2 && !o_hwrite && i_hready);
endmodule

// ===== bench/tb_spi_flash_dma.sv
`timescale 1ns/1ns
module tb_spi_flash_dma;
  reg clk = 1'b0, rst = 1'b1, lsb = 1'b0, le = 1'b0, go = 1'b0, clr = 1'b0;
  reg gsel = 1'b0, gout = 1'b0, goe = 1'b0, stall = 1'b0, hready = 1'b1, dph = 1'b0, dw = 1'b0;
  reg [1:0] mode = 2'h0, src = 2'h0, fsel = 2'h0;
  reg [7:0] fbyte = 8'h5B, dir = 8'h00;
  reg [63:0] cmd = 64'h0;
  reg [2:0] cnt = 3'h0, da = 3'h0;
  reg [23:0] wcnt = 24'h0, rcnt = 24'h0;
  reg [31:0] addr = 32'h0;
  reg [31:0] mem [0:7];
  wire busy, done, sck, mosi, seln, miso, hwrite, pout, poe;
  wire [63:0] crx;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize;
  integer num_errors = 0, cmp_count = 0, cyc = 0, i, j, n;
  time t0;
  spi_flash_dma dut_u (.i_sys_clk(clk), .i_rst(rst), .i_mode(mode), .i_lsb_first(lsb), .i_little_endian(le),
    .i_flash_clock_source_sel(src), .i_tx_fill_sel(fsel), .i_tx_fill_byte(fbyte), .i_command_bytes(cmd),
    .i_command_dir(dir), .i_command_count(cnt), .i_wdata_count(wcnt), .i_rdata_count(rcnt),
    .i_dma_start_addr(addr), .i_transaction_go(go), .i_complete_clear(clr), .o_busy(busy),
    .o_transaction_complete(done), .o_command_rx_bytes(crx), .o_haddr(haddr), .o_htrans(htrans),
    .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata), .i_hrdata(hrdata), .i_hready(hready),
    .o_sck(sck), .o_mosi(mosi), .o_flash_select_n(seln), .i_miso(miso), .i_general_pin_sel(gsel),
    .i_general_pin_out(gout), .i_general_pin_oe(goe), .o_general_pin_out(pout), .o_general_pin_oe(poe));
  flash_model fm (.i_sck(sck), .i_mosi(mosi), .i_sel_n(seln), .o_miso(miso), .i_mode(mode), .i_lsb(lsb));
  // ****
  // Clock, memory on the bus and run limit.
  // ****
  always #25 clk = ~clk;
  always @(posedge clk) begin
    hready <= #2 stall ? ~hready : 1'b1;
    if (hready) begin
      dph <= (htrans == 2'h2);
      da <= haddr[4:2];
      dw <= hwrite;
      if (dph && dw) mem[da] <= hwdata;
    end
    cyc = cyc + 1;
    if (cyc == 30000) begin
      num_errors = num_errors + 1;
      end_sim;
    end
  end
  assign hrdata = dph ? mem[da] : ~mem[da];
  // ****
  // Shared tasks.
  // ****
  function [7:0] lane(input [31:0] w, input integer k);
    lane = le ? w[8 * k +: 8] : w[8 * (3 - k) +: 8];
  endfunction
  task check(input [63:0] got, input [63:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task step;
    begin
      @(posedge clk);
      #2;
    end
  endtask
  task end_sim;
    begin
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // Starts a transaction, retries start while busy, waits for done and clears it.
  task run;
    begin
      go = 1'b1;
      step;
      go = 1'b0;
      repeat (40) step;
      go = 1'b1;
      step;
      go = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 20000) begin
        step;
        n = n + 1;
      end
      check({busy, seln, done}, 3'b011);
      step;
      check(done, 1'b1);
      clr = 1'b1;
      step;
      clr = 1'b0;
      step;
      check(done, 1'b0);
    end
  endtask
  // ****
  // Scenarios.
  // ****
  task pins;
    begin
      gout = 1'b1;
      goe = 1'b1;
      step;
      check({pout, poe}, 2'b11);
      gout = 1'b0;
      goe = 1'b0;
      step;
      check({pout, poe}, 2'b00);
      gsel = 1'b1;
      step;
      check({pout, poe}, 2'b11);
    end
  endtask
  task cmd_send;
    begin
      cmd = 64'h0123456789ABCDEF;
      dir = 8'hFF;
      cnt = 3'h4;
      for (i = 0; i < 4; i = i + 1) begin
        mode = i[1:0];
        lsb = i[0];
        src = i[1:0];
        step;
        step;
        fork
          run;
          begin
            @(sck) t0 = $time;
            @(sck) check(($time - t0) / 50, 4 << i);
          end
        join
        check(fm.nb, 4);
        for (j = 0; j < 4; j = j + 1) check(fm.rx_q[j], cmd[8 * j +: 8]);
      end
    end
  endtask
  task cmd_recv;
    begin
      cmd = 64'h9F;
      dir = 8'h01;
      cnt = 3'h0;
      mode = 2'h0;
      lsb = 1'b0;
      src = 2'h0;
      for (i = 0; i < 4; i = i + 1) begin
        fsel = i[1:0];
        step;
        run;
        check(fm.nb, 8);
        check(fm.rx_q[0], 8'h9F);
        for (j = 1; j < 8; j = j + 1) begin
          check(crx[8 * j +: 8], 8'h3C + 8'h11 * j);
          check(fm.rx_q[j], i == 0 ? 8'h00 : i == 1 ? 8'hFF : i == 2 ? 8'hAA : fbyte);
        end
      end
    end
  endtask
  task dma_read;
    begin
      cmd = 64'h03;
      cnt = 3'h1;
      rcnt = 24'h6;
      addr = 32'h8;
      stall = 1'b1;
      for (i = 0; i < 2; i = i + 1) begin
        le = i[0];
        for (j = 0; j < 8; j = j + 1) mem[j] = 32'hFFFFFFFF;
        step;
        run;
        for (j = 0; j < 8; j = j + 1) check(lane(mem[2 + j / 4], j % 4), j < 6 ? 8'h4D + 8'h11 * j : 0);
        check(mem[4], 32'hFFFFFFFF);
      end
    end
  endtask
  task dma_write;
    begin
      cmd = 64'h02;
      rcnt = 24'h0;
      wcnt = 24'h5;
      addr = 32'h0;
      mode = 2'h3;
      lsb = 1'b1;
      stall = 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
        le = i[0];
        mem[0] = 32'hA1B2C3D4;
        mem[1] = 32'h9876E5F6;
        step;
        run;
        check(fm.nb, 6);
        for (j = 0; j < 5; j = j + 1) check(fm.rx_q[1 + j], lane(mem[j / 4], j % 4));
      end
    end
  endtask
  initial begin
    repeat (6) step;
    rst = 1'b0;
    pins;
    cmd_send;
    cmd_recv;
    dma_read;
    dma_write;
    end_sim;
  end
endmodule
bind spi_flash_dma spi_flash_dma_chk chk_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_mode(i_mode),
  .i_transaction_go(i_transaction_go), .i_complete_clear(i_complete_clear), .i_hready(i_hready),
  .i_general_pin_sel(i_general_pin_sel), .i_general_pin_out(i_general_pin_out), .i_general_pin_oe(i_general_pin_oe),
  .o_busy(o_busy), .o_transaction_complete(o_transaction_complete), .o_sck(o_sck),
  .o_flash_select_n(o_flash_select_n), .o_htrans(o_htrans), .o_hsize(o_hsize), .o_haddr(o_haddr),
  .o_hwrite(o_hwrite), .o_general_pin_out(o_general_pin_out), .o_general_pin_oe(o_general_pin_oe));

// ===== common/spi_flash_dma_defines.vh
`ifndef SPI_FLASH_DMA_DEFINES_VH
`define SPI_FLASH_DMA_DEFINES_VH

// ****************************************************************
// Mode bits and serial timing.
// ****************************************************************
`define SFD_CPOL 1
`define SFD_CPHA 0
`define SFD_HALF_SRC0 6'h04
`define SFD_HALF_SRC1 6'h08
`define SFD_HALF_SRC2 6'h10
`define SFD_HALF_SRC3 6'h20
`define SFD_SRC0 2'h0
`define SFD_SRC1 2'h1
`define SFD_SRC2 2'h2
`define SFD_LAST_EDGE 5'h0F
`define SFD_EDGE_ZERO 5'h00
`define SFD_TICK_ONE 6'h01

// ****************************************************************
// Outgoing fill while receiving.
// ****************************************************************
`define SFD_FILL_ZERO 2'h0
`define SFD_FILL_ONE 2'h1
`define SFD_FILL_ALT 2'h2
`define SFD_PAT_ZERO 8'h00
`define SFD_PAT_ONE 8'hFF
`define SFD_PAT_ALT 8'hAA

// ****************************************************************
// Command buffer and counts.
// ****************************************************************
`define SFD_CMD_EIGHT 4'h8
`define SFD_CMD_ZERO 3'h0
`define SFD_LAST_LANE 2'h3
`define SFD_LANE_ZERO 2'h0
`define SFD_CNT_ZERO 24'h000000
`define SFD_CNT_ONE 24'h000001
`define SFD_WORD_ROUND 25'h0000003
`define SFD_WORDS_ZERO 23'h000000
`define SFD_WORDS_ONE 23'h000001
`define SFD_WORD_W 32

// ****************************************************************
// Bus master encodings.
// ****************************************************************
`define SFD_HTRANS_IDLE 2'h0
`define SFD_HTRANS_NONSEQ 2'h2
`define SFD_HSIZE_WORD 3'h2
`define SFD_ADDR_STEP 32'h00000004

`endif

// ===== hdl/spi_flash_dma.v
`timescale 1ns/1ns
`include "spi_flash_dma_defines.vh"

// Overview of operation
// - All four clock polarity and phase modes.
// - Acts only as serial master.
// - Transmit pin is MOSI, receive is MISO.
// - Four wires, select driven by hardware.
// - Command buffer start launches each transaction.
// - Bit order selectable, LSB or MSB.
// - Byte order selectable for data words.
// - Bulk data moves both directions.
// - Internal bus master uses software address.
// - Configuration arrives through separate control port.
// - Data crosses through a word buffer.
// - Serial rate picked from four sources.
// - Assigned pin bypasses its general function.
// - Sources are 1/8, 1/16, 1/32, 1/64 of system clock rate.
// - Direction bit: 1 sends, 0 receives.
// - Start runs command, data, then complete.
// - Receive fill: zero, one, alternate, byte.
module spi_flash_dma (
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_rst,
  // Configuration.
  input wire [1:0] i_mode,
  input wire i_lsb_first,
  input wire i_little_endian,
  input wire [1:0] i_flash_clock_source_sel,
  input wire [1:0] i_tx_fill_sel,
  input wire [7:0] i_tx_fill_byte,
  // Command buffer and transaction control.
  input wire [63:0] i_command_bytes,
  input wire [7:0] i_command_dir,
  input wire [2:0] i_command_count,
  input wire [23:0] i_wdata_count,
  input wire [23:0] i_rdata_count,
  input wire [31:0] i_dma_start_addr,
  input wire i_transaction_go,
  input wire i_complete_clear,
  // Status.
  output reg o_busy,
  output reg o_transaction_complete,
  output reg [63:0] o_command_rx_bytes,
  // Bus master.
  output reg [31:0] o_haddr,
  output wire [1:0] o_htrans,
  output reg o_hwrite,
  output wire [2:0] o_hsize,
  output reg [31:0] o_hwdata,
  input wire [31:0] i_hrdata,
  input wire i_hready,
  // Serial flash link.
  output reg o_sck,
  output reg o_mosi,
  output reg o_flash_select_n,
  input wire i_miso,
  // Shared general pin.
  input wire i_general_pin_sel,
  input wire i_general_pin_out,
  input wire i_general_pin_oe,
  output wire o_general_pin_out,
  output wire o_general_pin_oe
);

  localparam ST_IDLE = 4'h1;
  localparam ST_CMD = 4'h2;
  localparam ST_DATA = 4'h4;
  localparam ST_DONE = 4'h8;

  reg [3:0] state_q;
  reg cpol_q, cpha_q, lsb_q, le_q, rd_mode_q;
  reg [5:0] half_q;
  reg [7:0] fill_q;
  reg [63:0] cmd_q;
  reg [7:0] dir_q;
  reg [3:0] cmd_n_q;
  reg [2:0] idx_q;
  reg [23:0] left_q;
  reg [1:0] lane_q;
  reg [31:0] acc_q;
  reg acc_v_q;
  reg eng_busy_q, byte_done_q;
  reg [4:0] edge_q;
  reg [5:0] tick_q;
  reg [7:0] tx_sh_q, rx_sh_q;
  reg miso_m_q, miso_s_q;
  reg addr_ph_q, data_ph_q;
  reg [22:0] words_q;
  reg [5:0] half_d;
  reg [7:0] fill_d;
  reg [7:0] tx_byte;
  reg load_byte;
  wire [1:0] lane_sel;
  wire [24:0] wround;
  wire buf_wr_ready, buf_rd_valid;
  wire [31:0] buf_rd_data;
  wire dma_push, dma_pop, spi_pop, dma_idle, dma_start;

  function [2:0] bit_pos;
    input [2:0] k;
    input lsb;
    begin
      bit_pos = lsb ? k : ~k;
    end
  endfunction

  assign lane_sel = le_q ? lane_q : ~lane_q;
  assign wround = {1'b0, i_wdata_count} + `SFD_WORD_ROUND;
  assign o_htrans = addr_ph_q ? `SFD_HTRANS_NONSEQ : `SFD_HTRANS_IDLE;
  assign o_hsize = `SFD_HSIZE_WORD;
  assign o_general_pin_out = i_general_pin_sel ? o_flash_select_n : i_general_pin_out;
  assign o_general_pin_oe = i_general_pin_sel ? 1'b1 : i_general_pin_oe;

  // ****************************************************************
  // Clock source and fill pattern selection.
  // ****************************************************************
  always @* begin
    case (i_flash_clock_source_sel)
      `SFD_SRC0: half_d = `SFD_HALF_SRC0;
      `SFD_SRC1: half_d = `SFD_HALF_SRC1;
      `SFD_SRC2: half_d = `SFD_HALF_SRC2;
      default: half_d = `SFD_HALF_SRC3;
    endcase
    case (i_tx_fill_sel)
      `SFD_FILL_ZERO: fill_d = `SFD_PAT_ZERO;
      `SFD_FILL_ONE: fill_d = `SFD_PAT_ONE;
      `SFD_FILL_ALT: fill_d = `SFD_PAT_ALT;
      default: fill_d = i_tx_fill_byte;
    endcase
  end

  // ****************************************************************
  // Byte launch decision.
  // ****************************************************************
  always @* begin
    load_byte = 1'b0;
    tx_byte = fill_q;
    if (!eng_busy_q && !byte_done_q) begin
      if (state_q == ST_CMD) begin
        load_byte = 1'b1;
        tx_byte = dir_q[idx_q] ? cmd_q[{idx_q, 3'h0} +: 8] : fill_q;
      end else if (state_q == ST_DATA && left_q != `SFD_CNT_ZERO) begin
        if (!rd_mode_q) begin
          load_byte = buf_rd_valid;
          tx_byte = buf_rd_data[{lane_sel, 3'h0} +: 8];
        end else begin
          load_byte = ~acc_v_q;
          tx_byte = fill_q;
        end
      end
    end
  end

  assign spi_pop = load_byte & ~rd_mode_q & (state_q == ST_DATA) &
                   (lane_q == `SFD_LAST_LANE || left_q == `SFD_CNT_ONE);

  // ****************************************************************
  // Serial bit engine.
  // ****************************************************************
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      miso_m_q <= 1'b0;
      miso_s_q <= 1'b0;
      eng_busy_q <= 1'b0;
      byte_done_q <= 1'b0;
      edge_q <= `SFD_EDGE_ZERO;
      tick_q <= 6'h00;
      tx_sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      o_sck <= 1'b0;
      o_mosi <= 1'b0;
    end else begin
      miso_m_q <= i_miso;
      miso_s_q <= miso_m_q;
      byte_done_q <= 1'b0;
      if (state_q == ST_IDLE) begin
        o_sck <= i_mode[`SFD_CPOL];
      end else if (state_q == ST_DONE) begin
        o_sck <= cpol_q;
      end
      if (load_byte) begin
        eng_busy_q <= 1'b1;
        edge_q <= `SFD_EDGE_ZERO;
        tick_q <= 6'h00;
        tx_sh_q <= tx_byte;
        if (!cpha_q) begin
          o_mosi <= tx_byte[bit_pos(3'h0, lsb_q)];
        end
      end else if (eng_busy_q) begin
        if (tick_q == half_q - `SFD_TICK_ONE) begin
          tick_q <= 6'h00;
          o_sck <= ~o_sck;
          edge_q <= edge_q + 5'h01;
          if (edge_q[0] == cpha_q) begin
            rx_sh_q[bit_pos(edge_q[3:1], lsb_q)] <= miso_s_q;
          end
          if (cpha_q && !edge_q[0]) begin
            o_mosi <= tx_sh_q[bit_pos(edge_q[3:1], lsb_q)];
          end
          if (!cpha_q && edge_q[0] && edge_q != `SFD_LAST_EDGE) begin
            o_mosi <= tx_sh_q[bit_pos(edge_q[3:1] + 3'h1, lsb_q)];
          end
          if (edge_q == `SFD_LAST_EDGE) begin
            eng_busy_q <= 1'b0;
            byte_done_q <= 1'b1;
          end
        end else begin
          tick_q <= tick_q + 6'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Transaction sequencer.
  // ****************************************************************
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      cpol_q <= 1'b0;
      cpha_q <= 1'b0;
      lsb_q <= 1'b0;
      le_q <= 1'b0;
      rd_mode_q <= 1'b0;
      half_q <= `SFD_HALF_SRC0;
      fill_q <= `SFD_PAT_ZERO;
      cmd_q <= 64'h0000000000000000;
      dir_q <= 8'h00;
      cmd_n_q <= `SFD_CMD_EIGHT;
      idx_q <= 3'h0;
      left_q <= `SFD_CNT_ZERO;
      lane_q <= `SFD_LANE_ZERO;
      acc_q <= 32'h00000000;
      acc_v_q <= 1'b0;
      o_busy <= 1'b0;
      o_transaction_complete <= 1'b0;
      o_command_rx_bytes <= 64'h0000000000000000;
      o_flash_select_n <= 1'b1;
    end else begin
      if (acc_v_q && buf_wr_ready) begin
        acc_v_q <= 1'b0;
        acc_q <= 32'h00000000;
      end
      if (state_q == ST_DONE) begin
        o_transaction_complete <= 1'b1;
      end else if (i_complete_clear) begin
        o_transaction_complete <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          if (i_transaction_go) begin
            cpol_q <= i_mode[`SFD_CPOL];
            cpha_q <= i_mode[`SFD_CPHA];
            lsb_q <= i_lsb_first;
            le_q <= i_little_endian;
            half_q <= half_d;
            fill_q <= fill_d;
            cmd_q <= i_command_bytes;
            dir_q <= i_command_dir;
            cmd_n_q <= (i_command_count == `SFD_CMD_ZERO) ? `SFD_CMD_EIGHT : {1'b0, i_command_count};
            rd_mode_q <= (i_wdata_count == `SFD_CNT_ZERO);
            left_q <= (i_wdata_count != `SFD_CNT_ZERO) ? i_wdata_count : i_rdata_count;
            idx_q <= 3'h0;
            lane_q <= `SFD_LANE_ZERO;
            o_flash_select_n <= 1'b0;
            o_busy <= 1'b1;
            state_q <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (byte_done_q) begin
            if (!dir_q[idx_q]) begin
              o_command_rx_bytes[{idx_q, 3'h0} +: 8] <= rx_sh_q;
            end
            idx_q <= idx_q + 3'h1;
            if ({1'b0, idx_q} == cmd_n_q - 4'h1) begin
              state_q <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (byte_done_q) begin
            lane_q <= lane_q + 2'h1;
            left_q <= left_q - `SFD_CNT_ONE;
            if (rd_mode_q) begin
              acc_q[{lane_sel, 3'h0} +: 8] <= rx_sh_q;
              if (lane_q == `SFD_LAST_LANE || left_q == `SFD_CNT_ONE) begin
                acc_v_q <= 1'b1;
              end
            end
          end else if (left_q == `SFD_CNT_ZERO && !eng_busy_q && !acc_v_q && !buf_rd_valid && dma_idle &&
                       words_q == `SFD_WORDS_ZERO) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          o_flash_select_n <= 1'b1;
          o_busy <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Bus master moving data words.
  // ****************************************************************
  assign dma_idle = ~addr_ph_q & ~data_ph_q;
  assign dma_start = dma_idle & o_busy & (rd_mode_q ? buf_rd_valid : (words_q != `SFD_WORDS_ZERO && buf_wr_ready));
  assign dma_pop = dma_start & rd_mode_q;
  assign dma_push = data_ph_q & i_hready & ~o_hwrite;

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      addr_ph_q <= 1'b0;
      data_ph_q <= 1'b0;
      words_q <= `SFD_WORDS_ZERO;
      o_haddr <= 32'h00000000;
      o_hwrite <= 1'b0;
      o_hwdata <= 32'h00000000;
    end else begin
      if (state_q == ST_IDLE && i_transaction_go) begin
        o_haddr <= i_dma_start_addr;
        words_q <= wround[24:2];
      end else if (dma_start) begin
        addr_ph_q <= 1'b1;
        o_hwrite <= rd_mode_q;
        if (rd_mode_q) begin
          o_hwdata <= buf_rd_data;
        end
      end else if (addr_ph_q && i_hready) begin
        addr_ph_q <= 1'b0;
        data_ph_q <= 1'b1;
      end else if (data_ph_q && i_hready) begin
        data_ph_q <= 1'b0;
        o_haddr <= o_haddr + `SFD_ADDR_STEP;
        if (!o_hwrite) begin
          words_q <= words_q - `SFD_WORDS_ONE;
        end
      end
    end
  end

  word_buffer u_word_buffer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst | (state_q == ST_IDLE)),
    .i_wr_valid(rd_mode_q ? acc_v_q : dma_push),
    .o_wr_ready(buf_wr_ready),
    .i_wr_data(rd_mode_q ? acc_q : i_hrdata),
    .o_rd_valid(buf_rd_valid),
    .i_rd_ready(rd_mode_q ? dma_pop : spi_pop),
    .o_rd_data(buf_rd_data)
  );

endmodule

// ===== hdl/word_buffer.v
`timescale 1ns/1ns
`include "spi_flash_dma_defines.vh"

module word_buffer (
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_rst,
  // Fill side.
  input wire i_wr_valid,
  output wire o_wr_ready,
  input wire [`SFD_WORD_W-1:0] i_wr_data,
  // Drain side.
  output wire o_rd_valid,
  input wire i_rd_ready,
  output wire [`SFD_WORD_W-1:0] o_rd_data
);

  reg head_v_q;
  reg spare_v_q;
  reg [`SFD_WORD_W-1:0] head_q;
  reg [`SFD_WORD_W-1:0] spare_q;
  wire push;
  wire pop;

  assign o_wr_ready = ~spare_v_q;
  assign o_rd_valid = head_v_q;
  assign o_rd_data = head_q;
  assign push = i_wr_valid & ~spare_v_q;
  assign pop = i_rd_ready & head_v_q;

  // ****************************************************************
  // Two-entry store; the head word is the registered read data.
  // ****************************************************************
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      head_v_q <= 1'b0;
      spare_v_q <= 1'b0;
      head_q <= {`SFD_WORD_W{1'b0}};
      spare_q <= {`SFD_WORD_W{1'b0}};
    end else if (pop) begin
      if (spare_v_q) begin
        head_q <= spare_q;
        spare_v_q <= 1'b0;
      end else if (push) begin
        head_q <= i_wr_data;
      end else begin
        head_v_q <= 1'b0;
      end
    end else if (push) begin
      if (head_v_q) begin
        spare_q <= i_wr_data;
        spare_v_q <= 1'b1;
      end else begin
        head_q <= i_wr_data;
        head_v_q <= 1'b1;
      end
    end
  end

endmodule
